// [design/pcr_pkg.sv]
// Package for the power configuration register: offsets, fields, reset values, carriers
`default_nettype none
package pcr_pkg;

   // Byte offset of the power configuration register within the power manager window
   localparam logic [11:0] PCR_CFG_OFFSET = 12'h01c;

   // Field positions
   localparam int PCR_ADC_POWER_BIT = 30;
   localparam int PCR_CHAN_HI = 29;
   localparam int PCR_CHAN_LO = 27;
   localparam int PCR_CONV_BIT = 26;
   localparam int PCR_VREF_BIT = 25;
   localparam int PCR_IREF_BIT = 24;
   localparam int PCR_USB_POWER_BIT = 23;
   localparam int PCR_USB_SUSPEND_BIT = 22;
   localparam int PCR_USB_WAKE_BIT = 18;
   localparam int PCR_GPIO_WAKE_BIT = 17;
   localparam int PCR_RTC_WAKE_BIT = 16;
   localparam int PCR_ROM_MODE_BIT = 2;
   localparam int PCR_REMAP_BIT = 0;

   // Value after reset: only the converter power bit starts set
   localparam logic [31:0] PCR_CFG_RESET = 32'h4000_0000;
   // Bits that software can change; everything else is reserved or read-only
   localparam logic [31:0] PCR_CFG_WRITE_MASK = 32'h7fc7_0001;
   // Reset level of the bufferable-attribute synchroniser: bufferable, so mode reads 0
   localparam logic PCR_BUFF_SYNC_RESET = 1'b1;

   // Power and mapping controls driven out of the register
   typedef struct packed {
      logic adc_power_on;
      logic [2:0] reader_channel_power_enable;
      logic reader_converter_power_enable;
      logic reader_voltage_ref_power_enable;
      logic reader_current_ref_power_enable;
      logic usb_power_enable;
      logic usb_suspend_request;
      logic sram_at_zero;
   } pcr_power_s;

   // Raw wake sources arriving from other blocks or pins
   typedef struct packed {
      logic usb_bus_active;
      logic gpio_wake_event;
      logic rtc_wake_event;
   } pcr_wake_s;

endpackage
`default_nettype wire

// [design/pcr_power_config.sv]
// Power configuration register of the power manager, an APB slave
`default_nettype none

// Functional notes
// RULE1: Bit 30 powers the general converter while set; resets to one.
// RULE2: Bits 29:27 power the three reader channel front ends; reset 000.
// RULE3: Bits 26, 25, 24 power reader converter, voltage and current reference.
// RULE4: Software sets all reader power bits before using the card reader.
// RULE5: Bit 23 powers the USB block; reset leaves USB unpowered.
// RULE6: Bit 22 holds the USB block in suspend while set; resets to zero.
// RULE7: Bit 18 lets a non-idle USB bus wake the system.
// RULE8: Bit 17 lets a GPIO wake event wake the system.
// RULE9: Bit 16 lets a real-time-clock wake event wake the system.
// RULE10: Read-only bit 2 reads inverse of table bufferable attribute; zero at reset.
// RULE11: Bufferable means write-back of cache hits, otherwise write-through.
// RULE12: Bit 0 clear maps ROM at address zero, set maps SRAM.
// RULE13: Reserved bits read zero and ignore writes.
module pcr_power_config
   import pcr_pkg::*;
#(
   parameter int ADDR_WIDTH = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_WIDTH-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire pcr_wake_s wake_sources,
   input wire logic rom_table_bufferable,
   output pcr_power_s power_controls,
   output logic wake_request,
   output logic cache_write_back
);

   logic [31:0] power_configuration;
   logic [1:0] buff_sync;
   logic [1:0] usb_sync;
   logic [1:0] gpio_sync;
   logic [1:0] rtc_sync;
   logic rom_table_write_mode;
   logic hit;
   logic access;

   // Decode once; only the one word of this block answers
   assign hit = (paddr == ADDR_WIDTH'(PCR_CFG_OFFSET));
   assign access = psel & penable;

   // Zero wait states; every other offset ends with an error and no effect
   assign pready = 1'b1;
   assign pslverr = access & ~hit;

   // Register write: masked so reserved and read-only bits never store
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_configuration <= PCR_CFG_RESET; // RULE1 RULE2 RULE3 RULE5 RULE6 RULE12
      end else if (access && pwrite && hit) begin
         power_configuration <= pwdata & PCR_CFG_WRITE_MASK; // RULE13
      end
   end

   // Bufferable attribute comes from outside the clock domain: two flops first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buff_sync <= {PCR_BUFF_SYNC_RESET, PCR_BUFF_SYNC_RESET};
      end else begin
         buff_sync <= {buff_sync[0], rom_table_bufferable};
      end
   end

   // Status flop reports the write mode as the inverse of bufferable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rom_table_write_mode <= 1'b0; // RULE10
      end else begin
         rom_table_write_mode <= ~buff_sync[1]; // RULE10
      end
   end

   // Cache policy follows the synchronised attribute directly
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cache_write_back <= PCR_BUFF_SYNC_RESET;
      end else begin
         cache_write_back <= buff_sync[1]; // RULE11
      end
   end

   // Wake sources are asynchronous; synchronise each before gating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         usb_sync <= 2'h0;
         gpio_sync <= 2'h0;
         rtc_sync <= 2'h0;
      end else begin
         usb_sync <= {usb_sync[0], wake_sources.usb_bus_active};
         gpio_sync <= {gpio_sync[0], wake_sources.gpio_wake_event};
         rtc_sync <= {rtc_sync[0], wake_sources.rtc_wake_event};
      end
   end

   // Wake request is a level, registered so it never glitches on a write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_request <= 1'b0;
      end else begin
         wake_request <= (usb_sync[1] & power_configuration[PCR_USB_WAKE_BIT]) // RULE7
            | (gpio_sync[1] & power_configuration[PCR_GPIO_WAKE_BIT]) // RULE8
            | (rtc_sync[1] & power_configuration[PCR_RTC_WAKE_BIT]); // RULE9
      end
   end

   // Read data: combinational mux; reserved bits are zero from the mask
   always_comb begin
      prdata = 32'h0;
      if (psel && !pwrite && hit) begin
         prdata = power_configuration; // RULE13
         prdata[PCR_ROM_MODE_BIT] = rom_table_write_mode; // RULE10
      end
   end

   // Controls come straight from register flops. Enabling the card reader needs
   // all six reader bits; the block does not enforce that, software must.
   always_comb begin
      power_controls.adc_power_on = power_configuration[PCR_ADC_POWER_BIT]; // RULE1
      power_controls.reader_channel_power_enable =
         power_configuration[PCR_CHAN_HI:PCR_CHAN_LO]; // RULE2 RULE4
      power_controls.reader_converter_power_enable = power_configuration[PCR_CONV_BIT]; // RULE3
      power_controls.reader_voltage_ref_power_enable = power_configuration[PCR_VREF_BIT]; // RULE3
      power_controls.reader_current_ref_power_enable = power_configuration[PCR_IREF_BIT]; // RULE3
      power_controls.usb_power_enable = power_configuration[PCR_USB_POWER_BIT]; // RULE5
      power_controls.usb_suspend_request = power_configuration[PCR_USB_SUSPEND_BIT]; // RULE6
      power_controls.sram_at_zero = power_configuration[PCR_REMAP_BIT]; // RULE12
   end

endmodule // pcr_power_config
`default_nettype wire

// [dv/pcr_props.sv]
// Checker of the power configuration register ports
`default_nettype none
module pcr_props import pcr_pkg::*; #(parameter int ADDR_WIDTH = 12) (
   input wire logic pclk, input wire logic presetn, input wire logic psel,
   input wire logic penable, input wire logic pwrite, input wire logic [ADDR_WIDTH-1:0] paddr,
   input wire logic [31:0] pwdata, input wire logic [31:0] prdata, input wire logic pready,
   input wire logic pslverr, input wire logic rom_table_bufferable,
   input wire pcr_power_s power_controls, input wire logic cache_write_back
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Access phase to the one mapped word
   wire logic acc = psel && penable;
   wire logic hit = acc && paddr == PCR_CFG_OFFSET;
   wire logic [9:0] wv = {pwdata[30:22], pwdata[0]};
   // Attribute steady long enough to have crossed the synchroniser
   sequence buff_steady; $stable(rom_table_bufferable) [*6]; endsequence
   write_store_a: assert property (hit && pwrite |=> power_controls == $past(wv))
      else $error("write not stored");
   value_hold_a: assert property (!(hit && pwrite) |=> $stable(power_controls))
      else $error("value changed");
   read_back_a: assert property (hit && !pwrite |-> {prdata[30:22], prdata[0]} == power_controls)
      else $error("read back differs");
   reserved_zero_a: assert property (hit && !pwrite |-> (prdata & 32'h8038_fffa) == '0)
      else $error("reserved bit set");
   addr_error_a: assert property (acc |-> pslverr == (paddr != PCR_CFG_OFFSET))
      else $error("bad error flag");
   no_wait_a: assert property (acc |-> pready)
      else $error("wait state");
   table_mode_a: assert property (buff_steady ##0 (hit && !pwrite) |-> prdata[2] != rom_table_bufferable)
      else $error("mode bit wrong");
   write_back_a: assert property (buff_steady |-> cache_write_back == rom_table_bufferable)
      else $error("cache policy wrong");
endmodule // pcr_props
bind pcr_power_config pcr_props #(.ADDR_WIDTH(ADDR_WIDTH)) pcr_props_inst (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rom_table_bufferable,
   .power_controls, .cache_write_back);
`default_nettype wire

// [dv/pcr_power_config_bench.sv]
// Bench of the power configuration register
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module pcr_power_config_bench import pcr_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, buff = 1'h1;
   logic pready, pslverr, wake_request, cache_write_back;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic [32:0] rd;
   pcr_wake_s wake = '0;
   pcr_power_s pwr;
   int fails = 0, compares = 0;
   always #20 pclk = ~pclk;
   pcr_power_config pcr_power_config_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .wake_sources(wake), .rom_table_bufferable(buff),
      .power_controls(pwr), .wake_request, .cache_write_back);
   // One transfer; rd keeps the error flag above the read data
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk) psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = {pslverr, prdata};
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic end_of_test();
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Watchdog well beyond the few microseconds needed
   initial begin
      #100us fails++;
      end_of_test();
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, 12'h01c, '0);
      `CHK(rd, 33'h0_4000_0000)
      `CHK({pwr, cache_write_back, wake_request}, 12'h802)
      apb(1'h1, 12'h01c, 32'hffff_ffff);
      apb(1'h0, 12'h01c, '0);
      `CHK(rd, 33'h0_7fc7_0001)
      `CHK(pwr, 10'h3ff)
      apb(1'h1, 12'h020, '0);
      `CHK({rd[32], pwr}, 11'h7ff)
      $display("register test done");
      // Each wake source alone enabled; the others must not wake
      for (int i = 0; i < 3; i++) begin
         apb(1'h1, 12'h01c, 32'h0001_0000 << i);
         wake <= ~(3'h1 << i);
         repeat (5) @(posedge pclk);
         `CHK(wake_request, 1'h0)
         wake <= 3'h1 << i;
         repeat (5) @(posedge pclk);
         `CHK(wake_request, 1'h1)
      end
      buff <= 1'h0;
      repeat (5) @(posedge pclk);
      apb(1'h0, 12'h01c, '0);
      `CHK({rd[2], cache_write_back}, 2'h2)
      $display("input test done");
      end_of_test();
   end
endmodule // pcr_power_config_bench
`default_nettype wire
